// ===== one_time_enable_watchdog.sv
// Contract
// - watchdog is a 13-bit up-counter plus one write-only service register.
// - after any reset the watchdog is disabled and does not count.
// - writing 1E then E1 to the service register at A6 enables it.
// - enabled watchdog advances once per machine cycle while oscillator runs.
// - once armed, software cannot disable it; only reset or overflow can.
// - the same 1E, E1 pair while enabled clears the counter.
// - counter overflowing past 1FFF resets the device.
// - overflow drives the reset pin high for 96 oscillator periods unless reset-out disable bit 3 of 8E is set, which leaves the pin undriven.
// - service register write-only; counter neither readable nor writable.
// - in power-down the counter holds its value and does not advance.
// - after interrupt wake, counting waits until the interrupt input returns high.
// - idle-halt bit at 0 lets an enabled watchdog keep counting in idle.
// - idle-halt bit at 1 freezes the count in idle and resumes after.
// - idle-halt is bit 4 of auxiliary control at 8E, reset value 0.
`timescale 1ns/1ns
`include "watchdog_defines.svh"

module one_time_enable_watchdog
  import watchdog_pkg::*;
#(
  parameter int COUNTER_WIDTH = `WDOG_COUNTER_WIDTH,
  parameter int OSC_PER_CYCLE = `OSC_PER_MACHINE_CYCLE,
  parameter int PULSE_CYCLES = `RESET_PULSE_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_write_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_read_in,
  input wire logic power_down_in,
  input wire logic idle_in,
  input wire logic wake_int_n_in,
  output logic [7:0] sfr_rdata_out,
  output logic reset_pin_out,
  output logic reset_pin_oe_out,
  output logic watchdog_enabled_out,
  output logic ale_restrict_out
);

  localparam int PW = $clog2(OSC_PER_CYCLE);

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  logic service_write;
  logic aux_write;
  logic aux_read;
  logic [7:0] auxiliary_control;
  logic idle_count_halt;
  logic reset_out_off;

  // one decode shared by every access; a stopped oscillator blocks writes, not reads
  function automatic logic sfr_hit(
    input logic strobe,
    input logic stopped,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return strobe && !stopped && (addr == target);
  endfunction

  // writes are ignored while the oscillator is stopped
  assign service_write = sfr_hit(sfr_write_in, power_down_in, sfr_addr_in,
                                 `SFR_ADDR_SERVICE);
  assign aux_write = sfr_hit(sfr_write_in, power_down_in, sfr_addr_in,
                             `SFR_ADDR_AUX_CTRL);
  // reads are not gated by power-down; they change no state
  assign aux_read = sfr_hit(sfr_read_in, 1'b0, sfr_addr_in, `SFR_ADDR_AUX_CTRL);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      auxiliary_control <= `AUX_CTRL_RESET;
    end else if (aux_write) begin
      // reserved bits stay at zero
      auxiliary_control <= sfr_wdata_in & `AUX_CTRL_WRITE_MASK;
    end
  end

  assign idle_count_halt = auxiliary_control[`AUX_BIT_IDLE_HALT];
  assign reset_out_off = auxiliary_control[`AUX_BIT_RESET_OUT_OFF];

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ale_restrict_out <= 1'b0;
    end else begin
      ale_restrict_out <= auxiliary_control[`AUX_BIT_ALE_RESTRICT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads

  // the service register and the counter are not visible to software
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sfr_rdata_out <= 8'h00;
    end else if (aux_read) begin
      sfr_rdata_out <= auxiliary_control;
    end else begin
      sfr_rdata_out <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // key sequence

  logic key_done;

  service_key_detect u_key (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .write_in(service_write),
    .data_in(sfr_wdata_in),
    .done_out(key_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // power state tracking

  power_state_t power_state;
  power_state_t next_power_state;

  always_comb begin
    next_power_state = power_state;
    case (power_state)
      pm_running: begin
        if (power_down_in) begin
          next_power_state = pm_powered_down;
        end
      end
      pm_powered_down: begin
        if (!power_down_in) begin
          // an interrupt wake keeps the line low while the oscillator settles
          next_power_state = wake_int_n_in ? pm_running : pm_wake_hold;
        end
      end
      pm_wake_hold: begin
        if (wake_int_n_in) begin
          next_power_state = pm_running;
        end
      end
      default: begin
        next_power_state = pm_running;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      power_state <= pm_running;
    end else begin
      power_state <= next_power_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counting gate and machine cycle prescaler

  logic overflow;
  logic pulse_active;
  logic enabled;
  logic osc_halted;
  logic idle_frozen;
  logic count_allowed;
  logic [PW-1:0] prescale;
  logic machine_tick;

  // the state machine lags the pin by one cycle, so the pin itself is also used
  assign osc_halted = power_down_in || (power_state != pm_running);
  // the halt bit alone decides; with it clear idle does not touch the count
  assign idle_frozen = idle_in && idle_count_halt;

  always_comb begin
    count_allowed = enabled && !pulse_active;
    if (osc_halted) begin
      count_allowed = 1'b0;
    end
    if (idle_frozen) begin
      count_allowed = 1'b0;
    end
  end

  assign machine_tick = count_allowed && (prescale == PW'(OSC_PER_CYCLE - 1));

  always_ff @(posedge clk_in) begin
    if (rst_in || key_done) begin
      prescale <= '0;
    end else if (count_allowed) begin
      prescale <= machine_tick ? '0 : prescale + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enable latch: set by the key pair, cleared only by reset or overflow

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      enabled <= 1'b0;
    end else if (overflow) begin
      enabled <= 1'b0;
    end else if (key_done) begin
      enabled <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      watchdog_enabled_out <= 1'b0;
    end else begin
      watchdog_enabled_out <= enabled && !overflow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter

  logic [COUNTER_WIDTH-1:0] watchdog_counter;

  assign overflow = machine_tick &&
                    (watchdog_counter == COUNTER_WIDTH'(`WDOG_TERMINAL));

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      watchdog_counter <= '0;
    end else if (key_done || overflow) begin
      // servicing wins over a tick in the same cycle
      watchdog_counter <= '0;
    end else if (machine_tick) begin
      watchdog_counter <= watchdog_counter + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset pin drive

  logic pulse_raw;

  reset_pulse_gen #(
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_pulse (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(overflow),
    .pulse_out(pulse_raw)
  );

  // the pulse resets the whole device; rst_in normally follows from the pin,
  // so the pulse generator must not be cleared by its own pulse externally
  assign pulse_active = pulse_raw;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reset_pin_out <= 1'b0;
    end else begin
      reset_pin_out <= pulse_raw;
    end
  end

  // with the reset-out disable bit set the pin stays an input; the level is
  // still produced so the internal reset keeps the same timing
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reset_pin_oe_out <= 1'b0;
    end else begin
      reset_pin_oe_out <= pulse_raw && !reset_out_off;
    end
  end

endmodule

// ===== watchdog_defines.svh
`ifndef WATCHDOG_DEFINES_SVH
`define WATCHDOG_DEFINES_SVH

`define SFR_ADDR_SERVICE 8'hA6
`define SFR_ADDR_AUX_CTRL 8'h8E

`define SERVICE_KEY_FIRST 8'h1E
`define SERVICE_KEY_SECOND 8'hE1

`define AUX_BIT_ALE_RESTRICT 0
`define AUX_BIT_RESET_OUT_OFF 3
`define AUX_BIT_IDLE_HALT 4
`define AUX_CTRL_RESET 8'h00
`define AUX_CTRL_WRITE_MASK 8'h19

`define WDOG_COUNTER_WIDTH 13
`define WDOG_TERMINAL 13'h1FFF

`define OSC_PER_MACHINE_CYCLE 12
`define CLK_PERIOD_NS 100
`define OSC_PERIOD_NS 100
`define RESET_PULSE_OSC 96
`define RESET_PULSE_CYCLES \
  ((`RESET_PULSE_OSC * `OSC_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== watchdog_pkg.sv
package watchdog_pkg;

  typedef enum logic [0:0] {
    key_wait_first,
    key_wait_second
  } key_state_t;

  typedef enum logic [1:0] {
    pm_running,
    pm_powered_down,
    pm_wake_hold
  } power_state_t;

endpackage

// ===== service_key_detect.sv
`timescale 1ns/1ns
`include "watchdog_defines.svh"

module service_key_detect
  import watchdog_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic write_in,
  input wire logic [7:0] data_in,
  output logic done_out
);

  key_state_t key_state;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      key_state <= key_wait_first;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (write_in) begin
        // only the very next write after the first key may complete the pair
        if (data_in == `SERVICE_KEY_FIRST) begin
          key_state <= key_wait_second;
        end else if (key_state == key_wait_second && data_in == `SERVICE_KEY_SECOND) begin
          key_state <= key_wait_first;
          done_out <= 1'b1;
        end else begin
          key_state <= key_wait_first;
        end
      end
    end
  end

endmodule

// ===== reset_pulse_gen.sv
`timescale 1ns/1ns
`include "watchdog_defines.svh"

module reset_pulse_gen #(
  parameter int PULSE_CYCLES = `RESET_PULSE_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  output logic pulse_out
);

  localparam int CW = $clog2(PULSE_CYCLES + 1);

  logic [CW-1:0] remaining;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      remaining <= '0;
      pulse_out <= 1'b0;
    end else if (start_in) begin
      remaining <= CW'(PULSE_CYCLES - 1);
      pulse_out <= 1'b1;
    end else if (remaining != '0) begin
      remaining <= remaining - 1'b1;
    end else begin
      pulse_out <= 1'b0;
    end
  end

endmodule

// ===== watchdog_monitor.sv
`timescale 1ns/1ns
module watchdog_monitor #(
  parameter int PULSE_CYCLES = 96
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_write_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_read_in,
  input wire logic power_down_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic reset_pin_out,
  input wire logic watchdog_enabled_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  int hi_cnt;
  logic key1;
  always_ff @(posedge clk_in) begin
    hi_cnt <= (rst_in || !reset_pin_out) ? 0 : hi_cnt + 1;
  end
  // tracks only the service-register writes; other addresses must not break a pair
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      key1 <= 1'b0;
    end else if (sfr_write_in && sfr_addr_in == 8'hA6 && !power_down_in) begin
      key1 <= (sfr_wdata_in == 8'h1E);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_reset_quiet;
    $fell(rst_in) |-> !watchdog_enabled_out && !reset_pin_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("not idle after reset");
  property p_arm;
    key1 && sfr_write_in && sfr_addr_in == 8'hA6 && sfr_wdata_in == 8'hE1 && !power_down_in
      |-> ##[1:3] watchdog_enabled_out;
  endproperty
  a_arm: assert property (p_arm) else $error("key pair did not arm");
  property p_no_disable;
    $fell(watchdog_enabled_out) |-> ##[0:3] reset_pin_out;
  endproperty
  a_no_disable: assert property (p_no_disable) else $error("disabled without overflow");
  property p_pulse_len;
    $fell(reset_pin_out) |-> hi_cnt == PULSE_CYCLES;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");
  property p_pulse_max;
    hi_cnt <= PULSE_CYCLES;
  endproperty
  a_pulse_max: assert property (p_pulse_max) else $error("reset pulse too long");
  property p_rdata_idle;
    !$past(sfr_read_in) |-> sfr_rdata_out == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
  property p_rdata_service;
    $past(sfr_read_in && sfr_addr_in == 8'hA6) |-> sfr_rdata_out == 8'h00;
  endproperty
  a_rdata_service: assert property (p_rdata_service) else $error("service reg readable");
  property p_power_freeze;
    power_down_in && $past(power_down_in, 3) |-> !$rose(reset_pin_out);
  endproperty
  a_power_freeze: assert property (p_power_freeze) else $error("overflow in power-down");
endmodule

bind one_time_enable_watchdog watchdog_monitor #(.PULSE_CYCLES(PULSE_CYCLES)) u_watchdog_monitor (
  .clk_in(clk_in), .rst_in(rst_in), .sfr_addr_in(sfr_addr_in), .sfr_write_in(sfr_write_in),
  .sfr_wdata_in(sfr_wdata_in), .sfr_read_in(sfr_read_in), .power_down_in(power_down_in),
  .sfr_rdata_out(sfr_rdata_out), .reset_pin_out(reset_pin_out),
  .watchdog_enabled_out(watchdog_enabled_out));

// ===== tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] sfr_addr_in = 8'h00;
  logic [7:0] sfr_wdata_in = 8'h00;
  logic sfr_write_in = 1'b0;
  logic sfr_read_in = 1'b0;
  logic power_down_in = 1'b0;
  logic idle_in = 1'b0;
  logic wake_int_n_in = 1'b1;
  logic [7:0] sfr_rdata_out;
  logic reset_pin_out;
  logic reset_pin_oe_out;
  logic watchdog_enabled_out;
  logic ale_restrict_out;
  int fail_count = 0;
  int num_checks = 0;
  always #50 clk_in = ~clk_in;
  // 4-bit counter: overflow after 16 machine cycles of 12 clocks
  one_time_enable_watchdog #(.COUNTER_WIDTH(4), .OSC_PER_CYCLE(12), .PULSE_CYCLES(96))
    u_one_time_enable_watchdog (.clk_in(clk_in), .rst_in(rst_in), .sfr_addr_in(sfr_addr_in),
    .sfr_write_in(sfr_write_in), .sfr_wdata_in(sfr_wdata_in), .sfr_read_in(sfr_read_in),
    .power_down_in(power_down_in), .idle_in(idle_in), .wake_int_n_in(wake_int_n_in),
    .sfr_rdata_out(sfr_rdata_out), .reset_pin_out(reset_pin_out),
    .reset_pin_oe_out(reset_pin_oe_out), .watchdog_enabled_out(watchdog_enabled_out),
    .ale_restrict_out(ale_restrict_out));
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    sfr_write_in <= 1'b1;
    @(posedge clk_in);
    sfr_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    sfr_addr_in <= a;
    sfr_read_in <= 1'b1;
    @(posedge clk_in);
    sfr_read_in <= 1'b0;
    @(negedge clk_in);
    check(sfr_rdata_out, exp);
  endtask
  task automatic arm;
    wr(8'hA6, 8'h1E);
    wr(8'hA6, 8'hE1);
  endtask
  // the pin must stay low for n cycles
  task automatic quiet(input int n);
    logic h;
    h = 1'b0;
    repeat (n) begin
      @(negedge clk_in);
      h = h | reset_pin_out;
    end
    check({7'h00, h}, 8'h00);
  endtask
  // pulse must start between lo and hi cycles from now and last 96 cycles
  task automatic pulse(input int lo, input int hi, input logic oe);
    int n;
    int w;
    n = 0;
    w = 0;
    while (reset_pin_out !== 1'b1 && n < hi) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= hi) begin
      fail_count++;
      finish_test();
    end
    check({7'h00, n >= lo}, 8'h01);
    check({7'h00, reset_pin_oe_out}, {7'h00, oe});
    while (reset_pin_out === 1'b1 && w < 200) begin
      @(negedge clk_in);
      w++;
    end
    check(w[7:0], 8'h60);
    check({7'h00, watchdog_enabled_out}, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    check({7'h00, watchdog_enabled_out}, 8'h00);
    quiet(300);
    wr(8'hA6, 8'h1E);
    wr(8'hA6, 8'h55);
    wr(8'hA6, 8'hE1);
    wr(8'hA6, 8'hE1);
    wr(8'hA6, 8'h1E);
    wr(8'hA5, 8'h00);
    wr(8'hA6, 8'h00);
    quiet(4);
    check({7'h00, watchdog_enabled_out}, 8'h00);
    $display("test keys done");
    arm();
    quiet(4);
    check({7'h00, watchdog_enabled_out}, 8'h01);
    rd(8'hA6, 8'h00);
    repeat (4) begin
      quiet(110);
      arm();
      wr(8'hA6, 8'h00);
    end
    check({7'h00, watchdog_enabled_out}, 8'h01);
    pulse(175, 210, 1'b1);
    $display("test overflow done");
    arm();
    @(posedge clk_in);
    power_down_in <= 1'b1;
    wake_int_n_in <= 1'b0;
    quiet(500);
    @(posedge clk_in);
    power_down_in <= 1'b0;
    quiet(300);
    @(posedge clk_in);
    wake_int_n_in <= 1'b1;
    arm();
    pulse(170, 210, 1'b1);
    $display("test power done");
    arm();
    wr(8'h8E, 8'hFF);
    rd(8'h8E, 8'h19);
    check({7'h00, ale_restrict_out}, 8'h01);
    @(posedge clk_in);
    idle_in <= 1'b1;
    quiet(400);
    @(posedge clk_in);
    idle_in <= 1'b0;
    pulse(140, 210, 1'b0);
    wr(8'h8E, 8'h00);
    arm();
    check({7'h00, ale_restrict_out}, 8'h00);
    @(posedge clk_in);
    idle_in <= 1'b1;
    pulse(175, 210, 1'b1);
    $display("test idle done");
    finish_test();
  end
endmodule
